// >>> hw/timer_pkg.sv
package timer_pkg;
  // Structure
  localparam int NUM_TIMERS = 4;
  localparam int NUM_DMA_CH = 4;
  localparam int CH_W = 2;
  localparam int TMR_W = 2;
  localparam int CNT_W = 32;
  localparam int PRE_W = 8;
  localparam int DIV_W = 4;
  localparam int SYNC_W = 3;
  localparam int ST_W = 2;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;

  // Address layout: timer select above a 32-byte register window
  localparam int OFF_MSB = 4;
  localparam int TMR_LSB = 5;
  localparam int TMR_MSB = 6;
  localparam logic [OFF_MSB:0] OFF_CTRL = 5'h00;
  localparam logic [OFF_MSB:0] OFF_REF = 5'h04;
  localparam logic [OFF_MSB:0] OFF_CAPT = 5'h08;
  localparam logic [OFF_MSB:0] OFF_CNT = 5'h0c;
  localparam logic [OFF_MSB:0] OFF_STAT = 5'h10;
  localparam logic [OFF_MSB:0] OFF_MASK = 5'h14;

  // Control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_DIV16 = 2;
  localparam int CTRL_RESTART = 3;
  localparam int CTRL_CAPTURE = 4;
  localparam int CTRL_FALL = 5;
  localparam int CTRL_OUT = 6;
  localparam int CTRL_DMA_EN = 8;
  localparam int CTRL_CH = 10;
  localparam int CTRL_PRE = 16;

  // Status and mask bits
  localparam int ST_CAP = 0;
  localparam int ST_REF = 1;

  // Reset values and bus codes
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] REF_RST = 32'hffff_ffff;
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hf;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_TOGGLE = 2'b01,
    OUT_PULSE = 2'b10,
    OUT_SET = 2'b11
  } out_mode_t;
endpackage

// >>> hw/timer_unit_if.sv
`timescale 1ns/100ps
`default_nettype none
interface timer_unit_if;
  import timer_pkg::*;
  logic [DATA_W-1:0] ctrl;
  logic [CNT_W-1:0] ref_val;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] capt;
  logic cap_evt;
  logic ref_evt;
  logic out_pin;
  modport regs (output ctrl, ref_val,
    input count, capt, cap_evt, ref_evt, out_pin);
  modport unit (input ctrl, ref_val,
    output count, capt, cap_evt, ref_evt, out_pin);
endinterface
`default_nettype wire

// >>> hw/timer_unit.sv
`timescale 1ns/100ps
`default_nettype none
module timer_unit (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins
  input wire logic ext_timer_clock_in,
  input wire logic capture_in,
  // Register side
  timer_unit_if.unit tif
);
  import timer_pkg::*;

  logic [SYNC_W-1:0] clk_sync;
  logic [SYNC_W-1:0] cap_sync;
  logic clk_lvl;
  logic cap_lvl;
  logic [DIV_W-1:0] div_cnt;
  logic [PRE_W-1:0] pre_cnt;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] capt;
  logic cap_evt;
  logic ref_evt;
  logic out_pin;
  out_mode_t omode;

  // Configuration fields
  wire en = tif.ctrl[CTRL_EN];
  wire ext = tif.ctrl[CTRL_EXT];
  wire div16 = tif.ctrl[CTRL_DIV16];
  wire restart = tif.ctrl[CTRL_RESTART];
  wire capture = tif.ctrl[CTRL_CAPTURE];
  wire fall = tif.ctrl[CTRL_FALL];
  wire [PRE_W-1:0] prescale = tif.ctrl[CTRL_PRE +: PRE_W];
  assign omode = out_mode_t'(tif.ctrl[CTRL_OUT +: 2]);

  // Pin edges count only once stages two and three agree
  wire clk_stable = clk_sync[1] == clk_sync[2];
  wire ext_rise = clk_stable & clk_sync[2] & ~clk_lvl;
  wire cap_stable = cap_sync[1] == cap_sync[2];
  wire cap_rise = cap_stable & cap_sync[2] & ~cap_lvl;
  wire cap_fall = cap_stable & ~cap_sync[2] & cap_lvl;

  // Source select, pre-division, prescaler
  wire sys_tick = div16 ? (div_cnt == DIV_LAST) : 1'b1;
  wire src_tick = ext ? ext_rise : sys_tick;
  wire tick = en & src_tick & (pre_cnt == prescale);
  wire wrap = restart & (cnt == tif.ref_val);
  wire [CNT_W-1:0] next_cnt = wrap ? '0 : cnt + CNT_W'(1);
  wire cap_edge = capture & (fall ? cap_fall : cap_rise);
  wire evt = cap_evt | ref_evt;

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sync <= '0;
      cap_sync <= '0;
      clk_lvl <= 1'b0;
      cap_lvl <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], ext_timer_clock_in};
      cap_sync <= {cap_sync[1:0], capture_in};
      if (clk_stable) clk_lvl <= clk_sync[2];
      if (cap_stable) cap_lvl <= cap_sync[2];
    end
  end

  // Dividers restart when disabled so the first count has full length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= '0;
      pre_cnt <= '0;
    end else if (!en) begin
      div_cnt <= '0;
      pre_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
      if (src_tick) begin
        pre_cnt <= (pre_cnt == prescale) ? '0 : pre_cnt + PRE_W'(1);
      end
    end
  end

  // Counter, capture latch and event pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      capt <= '0;
      cap_evt <= 1'b0;
      ref_evt <= 1'b0;
    end else begin
      if (tick) cnt <= next_cnt;
      ref_evt <= tick & ~capture &
        (next_cnt == tif.ref_val);
      cap_evt <= en & cap_edge;
      if (en & cap_edge) capt <= cnt;
    end
  end

  // Output pin; set mode holds until software picks another mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_pin <= 1'b0;
    end else begin
      unique case (omode)
        OUT_OFF: out_pin <= 1'b0;
        OUT_TOGGLE: out_pin <= out_pin ^ evt;
        OUT_PULSE: out_pin <= evt;
        OUT_SET: out_pin <= out_pin | evt;
      endcase
    end
  end

  assign tif.count = cnt;
  assign tif.capt = capt;
  assign tif.cap_evt = cap_evt;
  assign tif.ref_evt = ref_evt;
  assign tif.out_pin = out_pin;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ext_settled: assert property (
    en && ext && !clk_stable |=> $stable(cnt))
    else $error("count moved on an unsettled external clock");
  // Software may switch the source at any time; only divided ticks are timed
  chk_div16_gap: assert property (
    en && !ext && div16 && src_tick |=>
    !(en && !ext && div16 && src_tick) [*8])
    else $error("divide-by-16 source ticked too early");
  chk_prescale_hold: assert property (
    !tick |=> $stable(cnt))
    else $error("count changed without a prescaler tick");
  chk_restart_zero: assert property (
    tick && restart && cnt == tif.ref_val |=> cnt == '0)
    else $error("restart did not reload zero");
  chk_free_step: assert property (
    tick && !restart |=> cnt == $past(cnt) + CNT_W'(1))
    else $error("free-running count did not step by one");
  chk_mode_excl: assert property (
    capture |=> !ref_evt)
    else $error("reference event raised in capture mode");
  chk_capture_latch: assert property (
    en && cap_edge |=> cap_evt && capt == $past(cnt))
    else $error("capture edge did not latch the count");
  chk_toggle_out: assert property (
    evt && omode == OUT_TOGGLE |=> out_pin != $past(out_pin))
    else $error("toggle mode did not toggle the pin");
  chk_pulse_out: assert property (
    omode == OUT_PULSE |=> out_pin == $past(evt))
    else $error("pulse mode did not follow the event");
endmodule
`default_nettype wire

// >>> hw/dma_capable_timer.sv
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dma_capable_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [timer_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [timer_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [timer_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer pins
  input wire logic [timer_pkg::NUM_TIMERS-1:0] ext_timer_clock_in,
  input wire logic [timer_pkg::NUM_TIMERS-1:0] capture_in,
  output logic [timer_pkg::NUM_TIMERS-1:0] compare_out,
  // System requests
  output logic irq,
  output logic [timer_pkg::NUM_DMA_CH-1:0] dma_chan_req
);
  import timer_pkg::*;

  // Address helpers shared by both bus phases
  function automatic logic [TMR_W-1:0] tmr_of(input logic [ADDR_W-1:0] a);
    return a[TMR_MSB:TMR_LSB];
  endfunction

  function automatic logic [OFF_MSB:0] off_of(input logic [ADDR_W-1:0] a);
    return a[OFF_MSB:0];
  endfunction

  function automatic logic in_map(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:TMR_MSB+1] == '0;
  endfunction

  timer_unit_if tif [NUM_TIMERS] ();

  logic [DATA_W-1:0] ctrl [NUM_TIMERS];
  logic [CNT_W-1:0] ref_val [NUM_TIMERS];
  logic [ST_W-1:0] status [NUM_TIMERS];
  logic [ST_W-1:0] mask [NUM_TIMERS];
  logic [ST_W-1:0] next_status [NUM_TIMERS];
  logic [ST_W-1:0] st_set [NUM_TIMERS];
  logic [CNT_W-1:0] cnt_of [NUM_TIMERS];
  logic [CNT_W-1:0] capt_of [NUM_TIMERS];
  logic [CH_W-1:0] ch_of [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] evt_dma;
  logic [NUM_TIMERS-1:0] irq_vec;
  logic [NUM_TIMERS-1:0] next_out;
  logic [NUM_DMA_CH-1:0] next_dma;

  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;

  // Address phase decode
  wire acc = hsel & htrans[1] & hready;
  wire is_word = hsize == SIZE_WORD;
  wire [TMR_W-1:0] rd_tmr = tmr_of(haddr);
  wire [OFF_MSB:0] rd_off = off_of(haddr);
  wire [TMR_W-1:0] wr_tmr = tmr_of(wr_addr);
  wire [OFF_MSB:0] wr_off = off_of(wr_addr);

  // Read selection; holes in the map read as zero
  wire [DATA_W-1:0] rd_word =
    !in_map(haddr) ? '0 :
    (rd_off == OFF_CTRL) ? ctrl[rd_tmr] :
    (rd_off == OFF_REF) ? ref_val[rd_tmr] :
    (rd_off == OFF_CAPT) ? capt_of[rd_tmr] :
    (rd_off == OFF_CNT) ? cnt_of[rd_tmr] :
    (rd_off == OFF_STAT) ? DATA_W'(status[rd_tmr]) :
    (rd_off == OFF_MASK) ? DATA_W'(mask[rd_tmr]) : '0;

  // Bus phases; zero wait, so hreadyout never drops and hresp stays OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= acc & hwrite & is_word & in_map(haddr);
      if (acc) wr_addr <= haddr;
      hrdata <= (acc & ~hwrite) ? rd_word : '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // One register set and one counter per timer
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    wire sel = wr_pend & (wr_tmr == TMR_W'(t));
    wire [ST_W-1:0] st_clr =
      (sel & (wr_off == OFF_STAT)) ? hwdata[ST_W-1:0] : '0;

    // Events set flags; a set in the clearing cycle wins
    assign st_set[t] = {tif[t].ref_evt, tif[t].cap_evt};
    assign next_status[t] = (status[t] & ~st_clr) | st_set[t];
    assign irq_vec[t] = |(next_status[t] & mask[t]);
    assign evt_dma[t] = ctrl[t][CTRL_DMA_EN] &
      (tif[t].cap_evt | tif[t].ref_evt);
    assign ch_of[t] = ctrl[t][CTRL_CH +: CH_W];
    assign cnt_of[t] = tif[t].count;
    assign capt_of[t] = tif[t].capt;
    assign next_out[t] = tif[t].out_pin;
    assign tif[t].ctrl = ctrl[t];
    assign tif[t].ref_val = ref_val[t];

    // Software-written registers
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl[t] <= CTRL_RST;
        ref_val[t] <= REF_RST;
        mask[t] <= '0;
        status[t] <= '0;
      end else begin
        if (sel & (wr_off == OFF_CTRL)) ctrl[t] <= hwdata;
        if (sel & (wr_off == OFF_REF)) ref_val[t] <= hwdata;
        if (sel & (wr_off == OFF_MASK)) mask[t] <= hwdata[ST_W-1:0];
        status[t] <= next_status[t];
      end
    end

    timer_unit u_unit (
      .hclk(hclk),
      .hresetn(hresetn),
      .ext_timer_clock_in(ext_timer_clock_in[t]),
      .capture_in(capture_in[t]),
      .tif(tif[t])
    );
  end

  // DMA crossbar: each timer feeds the channel that software names
  always_comb begin
    next_dma = '0;
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (evt_dma[t]) next_dma[ch_of[t]] = 1'b1;
    end
  end

  // Registered outputs; pins see the unit one clock later for clean timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
      dma_chan_req <= '0;
      compare_out <= '0;
    end else begin
      irq <= |irq_vec;
      dma_chan_req <= next_dma;
      compare_out <= next_out;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_unit_isolation: assert property (
    wr_pend && wr_tmr == TMR_W'(0) |=> $stable(ctrl[1]) && $stable(ref_val[1]))
    else $error("write to one timer disturbed another");
  chk_irq_follow: assert property (
    st_set[0][ST_REF] && mask[0][ST_REF] |=> irq)
    else $error("unmasked event did not raise the interrupt");
  // Irq changes on the same edge as the status and uses the mask of the cycle before
  chk_irq_masked: assert property (
    (status[0] & $past(mask[0])) == '0 &&
    (status[1] & $past(mask[1])) == '0 &&
    (status[2] & $past(mask[2])) == '0 &&
    (status[3] & $past(mask[3])) == '0 |-> !irq)
    else $error("interrupt raised with nothing unmasked");
  chk_read_mask: assert property (
    acc && !hwrite && in_map(haddr) && rd_off == OFF_MASK
    |=> hrdata == DATA_W'($past(mask[rd_tmr])))
    else $error("mask readback differs from the register");
  chk_dma_route: assert property (
    evt_dma[0] |=> dma_chan_req[$past(ch_of[0])])
    else $error("DMA request missing on the chosen channel");
  chk_cap_flag: assert property (
    tif[1].cap_evt |=> status[1][ST_CAP])
    else $error("capture flag not set");
  // Sticky until software writes a one; a clear in flight is allowed
  chk_cap_sticky: assert property (
    status[1][ST_CAP] && !g_tmr[1].st_clr[ST_CAP] |=> status[1][ST_CAP])
    else $error("capture flag dropped without a clear");
  chk_stat_clear: assert property (
    g_tmr[0].sel && wr_off == OFF_STAT && hwdata[ST_REF] &&
    !st_set[0][ST_REF] |=> !status[0][ST_REF])
    else $error("reference flag survived a clear");
  chk_ref_flag: assert property (
    tif[0].ref_evt |=> status[0][ST_REF])
    else $error("reference flag not set");
  chk_pin_delay: assert property (
    1'b1 |=> compare_out[0] == $past(tif[0].out_pin))
    else $error("compare pin does not follow the unit");

  cov_capture: cover property (tif[1].cap_evt ##1 status[1][ST_CAP]);
  cov_restart: cover property (
    ctrl[0][CTRL_RESTART] && tif[0].ref_evt ##[1:40] tif[0].ref_evt);
  cov_dma: cover property (dma_chan_req != '0);
  cov_irq: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// >>> sim/timer_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module timer_pins_model (
  // Clock
  input wire logic hclk,
  // Pins toward the timers
  output logic [timer_pkg::NUM_TIMERS-1:0] ext_timer_clock_in,
  output logic [timer_pkg::NUM_TIMERS-1:0] capture_in,
  input wire logic [timer_pkg::NUM_TIMERS-1:0] compare_out
);
  import timer_pkg::*;
  int toggles [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] last_out;

  // Pins rest low, as after reset, so no stray edge is seen
  initial begin
    ext_timer_clock_in = '0;
    capture_in = '0;
    last_out = '0;
  end

  // Count level changes on each output pin
  always @(posedge hclk) begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      // Only real level changes count, not the unknown before reset
      if (compare_out[i] === ~last_out[i]) begin
        toggles[i]++;
      end
    end
    last_out <= compare_out;
  end

  // Slow clock: each level lasts longer than the synchroniser delay
  task automatic ext_pulses(input int t, input int n);
    repeat (n) begin
      @(posedge hclk);
      ext_timer_clock_in[t] <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_timer_clock_in[t] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask

  // One level change on a capture pin, right after an edge
  task automatic cap_drive(input int t, input logic lvl);
    @(posedge hclk);
    capture_in[t] <= lvl;
  endtask
endmodule
`default_nettype wire

// >>> sim/dma_capable_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
module dma_capable_timer_test;
  import timer_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [ADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = SIZE_WORD;
  logic [DATA_W-1:0] hwdata = '0;
  wire logic hready;
  logic [DATA_W-1:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [NUM_TIMERS-1:0] ext_clk;
  logic [NUM_TIMERS-1:0] cap_pin;
  logic [NUM_TIMERS-1:0] compare_out;
  logic irq;
  logic [NUM_DMA_CH-1:0] dma_chan_req;
  logic [31:0] d;
  logic [31:0] c;
  int err_total = 0;
  int num_checks = 0;
  int dma_hit = 0;
  int dma_other = 0;
  logic [31:0] rst_tab [7] = '{CTRL_RST, REF_RST, 0, 0, 0, 0, 0};

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;

  always #10 hclk = ~hclk;

  dma_capable_timer i_dma_capable_timer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_timer_clock_in(ext_clk),
    .capture_in(cap_pin), .compare_out(compare_out), .irq(irq),
    .dma_chan_req(dma_chan_req));

  timer_pins_model i_timer_pins_model (.hclk(hclk),
    .ext_timer_clock_in(ext_clk), .capture_in(cap_pin),
    .compare_out(compare_out));

  // Tally DMA pulses; only channel 2 is ever routed
  always @(posedge hclk) begin
    if (dma_chan_req[2] === 1'b1) dma_hit++;
    if (|(dma_chan_req & 4'b1011) === 1'b1) dma_other++;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input int t, input logic [4:0] off, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {25'h0, t[1:0], off};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", 32'(hresp), 32'h0);
    hsel <= 1'b0;
  endtask

  task automatic wr(input int t, input logic [4:0] off, input logic [31:0] v);
    logic [31:0] x;
    bus(t, off, 1'b1, v, x);
  endtask

  task automatic rd(input int t, input logic [4:0] off, output logic [31:0] v);
    bus(t, off, 1'b0, 32'h0, v);
  endtask

  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this cuts a hang
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of every register of timer 3 and of a hole
    for (int i = 0; i < 7; i++) begin
      rd(3, 5'(i * 4), d);
      check("reset value", d, rst_tab[i]);
    end
    wr(3, OFF_CAPT, 32'h1234_5678);
    rd(3, OFF_CAPT, d);
    check("capture read only", d, 32'h0);
    // Restart compare: toggle pin, DMA on channel 2, interrupt
    wr(0, OFF_REF, 32'h2);
    wr(0, OFF_MASK, 32'h2);
    wr(0, OFF_CTRL, 32'h0000_0949);
    repeat (30) @(posedge hclk);
    rd(0, OFF_CNT, d);
    check("restart range", 32'(d <= 32'h2), 32'h1);
    rd(0, OFF_STAT, d);
    check("ref flag", d, 32'h2);
    check("irq on", 32'(irq), 32'h1);
    wr(0, OFF_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    check("irq masked", 32'(irq), 32'h0);
    wr(0, OFF_CTRL, 32'h0);
    check("dma pulses", 32'(dma_hit >= 5), 32'h1);
    check("dma routing", 32'(dma_other), 32'h0);
    check("toggles", 32'(i_timer_pins_model.toggles[0] >= 5),
          32'h1);
    wr(0, OFF_STAT, 32'h3);
    rd(0, OFF_STAT, d);
    check("stat clear", d, 32'h0);
    // Rising-edge capture on timer 1
    wr(1, OFF_MASK, 32'h1);
    wr(1, OFF_CTRL, 32'h0000_0011);
    repeat (5) @(posedge hclk);
    i_timer_pins_model.cap_drive(1, 1'b1);
    repeat (10) @(posedge hclk);
    rd(1, OFF_STAT, d);
    check("cap flag", d, 32'h1);
    check("cap irq", 32'(irq), 32'h1);
    rd(1, OFF_CAPT, c);
    rd(1, OFF_CNT, d);
    check("cap value", 32'(c != 0 && c < d), 32'h1);
    // Falling-edge capture on timer 2 ignores a rise
    wr(2, OFF_CTRL, 32'h0000_00b1);
    i_timer_pins_model.cap_drive(2, 1'b1);
    repeat (10) @(posedge hclk);
    rd(2, OFF_STAT, d);
    check("rise ignored", d, 32'h0);
    i_timer_pins_model.cap_drive(2, 1'b0);
    repeat (10) @(posedge hclk);
    rd(2, OFF_STAT, d);
    check("fall seen", d, 32'h1);
    // Pulse mode: one high cycle on the pin, so two level changes
    check("pulse out", i_timer_pins_model.toggles[2], 32'h2);
    // External clock on timer 3, prescaler divides by two
    wr(3, OFF_CTRL, 32'h0001_0003);
    i_timer_pins_model.ext_pulses(3, 6);
    repeat (6) @(posedge hclk);
    rd(3, OFF_CNT, d);
    check("ext count", d, 32'h3);
    // System clock divided by 16, free running
    wr(0, OFF_REF, 32'h8);
    rd(0, OFF_CNT, c);
    wr(0, OFF_CTRL, 32'h0000_00c5);
    repeat (160) @(posedge hclk);
    // Set mode: the match at 8 raises the pin and it stays up
    check("set holds", 32'(compare_out[0]), 32'h1);
    wr(0, OFF_CTRL, 32'h0);
    rd(0, OFF_CNT, d);
    d = d - c;
    check("div16 count", 32'(d >= 9 && d <= 11), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
